// [rtl/isr_readout_top.sv]
// Row sequencing, black level, and parallel or serial pixel output
//
// Contract
// - In parallel mode one pixel leaves every two master clock cycles, half the master rate.
// - Rows are stepped in turn, each reset and later read.
// - Exposure is the row count between reset and read of a row.
// - Column samples get per-colour analog offset and gain, then 10-bit conversion.
// - Digital chain adds offset, digital gain and optional defect fixing.
// - Shielded pixel samples drive the black level offset correction.
// - Settings are 16-bit words loaded by an outside serial controller.
// - Even rows carry green and red, odd rows blue and green.
// - Offset and gain have a separate setting per colour channel.
// - Mode pins 00 pick parallel, 01 serial; 10 and 11 unused.
// - Parallel mode drives ten data lines, line, frame and pixel clock.
// - Both modes produce a VGA image with all timing made here.
// - Serial mode packs data, line and frame into one differential stream.
// - While line is high, one sample appears each pixel clock period.
// - Pixel clock rises half a master period after data changes.
// - The pixel clock keeps toggling, blanking included.
`timescale 1ns/1ps
module isr_readout_top #(
  parameter int ACT_COLS  = isr_pkg::ACT_COLS,
  parameter int ACT_ROWS  = isr_pkg::ACT_ROWS,
  parameter int HBLANK    = isr_pkg::HBLANK,
  parameter int VBLANK    = isr_pkg::VBLANK,
  parameter int DARK_ROWS = isr_pkg::DARK_ROWS
) (
  // Clocks and reset
  input  wire logic                                   clk_i,
  input  wire logic                                   ser_clk_i,
  input  wire logic                                   resetn_i,
  // Mode pins
  input  wire logic                                   function_select_hi_i,
  input  wire logic                                   function_select_lo_i,
  // Configuration words
  input  wire logic [isr_pkg::CFG_W-1:0]              exposure_rows_i,
  input  wire logic [isr_pkg::N_COLOUR-1:0][15:0]     ana_gain_i,
  input  wire logic [isr_pkg::N_COLOUR-1:0][15:0]     ana_offset_i,
  input  wire logic [isr_pkg::N_COLOUR-1:0][15:0]     dig_gain_i,
  input  wire logic [isr_pkg::N_COLOUR-1:0][15:0]     dig_offset_i,
  input  wire logic                                   defect_en_i,
  // Array and converter control
  output logic                                        row_reset_o,
  output logic [isr_pkg::CNT_W-1:0]                   row_reset_addr_o,
  output logic                                        row_read_o,
  output logic [isr_pkg::CNT_W-1:0]                   row_read_addr_o,
  output logic [1:0]                                  afe_colour_o,
  output logic [isr_pkg::CFG_W-1:0]                   afe_gain_o,
  output logic [isr_pkg::CFG_W-1:0]                   afe_offset_o,
  output logic                                        adc_sample_o,
  input  wire logic [isr_pkg::PIX_W-1:0]              adc_data_i,
  // Parallel output
  output logic [isr_pkg::PIX_W-1:0]                   pix_data_o,
  output logic                                        line_valid_o,
  output logic                                        frame_valid_o,
  output logic                                        sample_out_clock_o,
  // Serial differential output
  output logic                                        ser_p_o,
  output logic                                        ser_n_o
);
  localparam int LINE_LEN  = ACT_COLS + HBLANK;
  localparam int READ_ROWS = DARK_ROWS + ACT_ROWS;
  localparam int FRM_ROWS  = READ_ROWS + VBLANK;
  localparam int CW        = isr_pkg::CNT_W;
  localparam int BW        = isr_pkg::PIX_W + isr_pkg::BLACK_LOG2;

  isr_pix_if raw_if ();
  isr_pix_if cor_if ();

  logic [1:0]          mode_s1;
  logic [1:0]          mode_s2;
  logic [1:0]          mode;
  logic                ph;
  logic                adv;
  logic                ser_mode;
  logic [CW-1:0]       col;
  logic [CW-1:0]       row;
  logic [CW-1:0]       arow;
  logic                in_act;
  logic                in_dark;
  logic                col_act;
  logic [CW:0]         rst_sum;
  logic [CW-1:0]       rst_row;
  logic [15:0]         expo;
  logic [BW-1:0]       blk_acc;
  logic [isr_pkg::BLACK_LOG2:0] blk_cnt;
  logic [isr_pkg::PIX_W-1:0]    black;
  logic [isr_pkg::SER_W-1:0]    hold_word;
  logic                req_t;
  logic                ack_c1;
  logic                ack_c2;
  logic                hold_full;
  logic                req_l1;
  logic                req_l2;
  logic                ack_l;
  isr_pkg::isr_ser_e   ser_st;
  logic [isr_pkg::SER_W-1:0]    ser_sh;
  logic [3:0]          ser_cnt;
  logic                ser_q;

  // Mode pins come from outside and pass three flops first
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_s1 <= isr_pkg::MODE_PAR;
      mode_s2 <= isr_pkg::MODE_PAR;
      mode    <= isr_pkg::MODE_PAR;
    end else begin
      mode_s1 <= {function_select_hi_i, function_select_lo_i};
      mode_s2 <= mode_s1;
      mode    <= mode_s2;
    end
  end

  assign ser_mode = (mode == isr_pkg::MODE_SER);

  // Pixel phase: one pixel slot every two master clocks
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ph <= 1'b0;
    end else begin
      ph <= ~ph;
    end
  end

  // Serial mode stalls the scan while the link still owns the last word
  assign adv = !ph && !(ser_mode && hold_full);

  // Column and row position of the scan
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      col <= '0;
      row <= '0;
    end else if (adv) begin
      if (col == CW'(LINE_LEN - 1)) begin
        col <= '0;
        row <= (row == CW'(FRM_ROWS - 1)) ? '0 : row + 1'b1;
      end else begin
        col <= col + 1'b1;
      end
    end
  end

  assign in_dark = (row < CW'(DARK_ROWS));
  assign in_act  = !in_dark && (row < CW'(READ_ROWS));
  assign col_act = (col < CW'(ACT_COLS));
  assign arow    = row - CW'(DARK_ROWS);

  // Reset pointer leads the read pointer by the exposure in rows
  always_comb begin
    expo = exposure_rows_i;
    if (expo > 16'(FRM_ROWS - 1)) begin
      expo = 16'(FRM_ROWS - 1);
    end
    rst_sum = {1'b0, row} + expo[CW:0];
    if (rst_sum >= (CW+1)'(FRM_ROWS)) begin
      rst_sum = rst_sum - (CW+1)'(FRM_ROWS);
    end
    rst_row = rst_sum[CW-1:0];
  end

  // Row reset and row read strobes at the start of a row time, only for target rows among the shielded and image rows
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      row_reset_o      <= 1'b0;
      row_reset_addr_o <= '0;
      row_read_o       <= 1'b0;
      row_read_addr_o  <= '0;
    end else begin
      row_reset_o <= adv && (col == '0) && (rst_row < CW'(READ_ROWS));
      row_read_o  <= adv && (col == '0) && (row < CW'(READ_ROWS));
      if (adv && (col == '0)) begin
        row_reset_addr_o <= rst_row;
        row_read_addr_o  <= row;
      end
    end
  end

  // Analog settings follow the colour of the column being converted
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      afe_colour_o <= 2'h0;
      afe_gain_o   <= '0;
      afe_offset_o <= '0;
      adc_sample_o <= 1'b0;
    end else begin
      afe_colour_o <= {arow[0], col[0]};
      afe_gain_o   <= ana_gain_i[{arow[0], col[0]}];
      afe_offset_o <= ana_offset_i[{arow[0], col[0]}];
      adc_sample_o <= adv && col_act && (row < CW'(READ_ROWS));
    end
  end

  // Average of shielded samples gives the black level
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      blk_acc <= '0;
      blk_cnt <= '0;
      black   <= '0;
    end else if (adv) begin
      if (row == CW'(FRM_ROWS - 1) && col == '0) begin  // Clear early so row 0 col 0 counts
        blk_acc <= '0;
        blk_cnt <= '0;
      end else if (in_dark && col_act && !blk_cnt[isr_pkg::BLACK_LOG2]) begin
        blk_acc <= blk_acc + BW'(adc_data_i);
        blk_cnt <= blk_cnt + 1'b1;
      end else if (blk_cnt[isr_pkg::BLACK_LOG2] && in_act) begin
        black   <= blk_acc[BW-1 -: isr_pkg::PIX_W];
      end
    end
  end

  // Raw stream into the correction stage
  always_comb begin
    raw_if.valid  = adv;
    raw_if.lv     = in_act && col_act;
    raw_if.fv     = in_act;
    raw_if.colour = {arow[0], col[0]};
    raw_if.data   = adc_data_i;
  end

  isr_pix_proc u_proc (
    .clk_i        (clk_i),
    .resetn_i     (resetn_i),
    .black_i      (black),
    .dig_offset_i (dig_offset_i),
    .dig_gain_i   (dig_gain_i),
    .defect_en_i  (defect_en_i),
    .raw          (raw_if.snk),
    .cor          (cor_if.src)
  );

  // Parallel outputs change one master clock after the corrected pixel
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pix_data_o    <= '0;
      line_valid_o  <= 1'b0;
      frame_valid_o <= 1'b0;
    end else if (cor_if.valid) begin
      if (mode == isr_pkg::MODE_PAR) begin
        pix_data_o    <= cor_if.data;
        line_valid_o  <= cor_if.lv;
        frame_valid_o <= cor_if.fv;
      end else begin
        pix_data_o    <= '0;
        line_valid_o  <= 1'b0;
        frame_valid_o <= 1'b0;
      end
    end
  end

  // Pixel clock rises on the falling master edge after each data update
  always_ff @(negedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sample_out_clock_o <= 1'b0;
    end else begin
      sample_out_clock_o <= ~ph;
    end
  end

  // Hold register handed to the link side by a toggle handshake
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hold_word <= '0;
      req_t     <= 1'b0;
    end else if (cor_if.valid && ser_mode) begin
      hold_word <= {cor_if.fv, cor_if.lv, cor_if.data};
      req_t     <= ~req_t;
    end
  end

  // Acknowledge returns through two flops
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_c1 <= 1'b0;
      ack_c2 <= 1'b0;
    end else begin
      ack_c1 <= ack_l;
      ack_c2 <= ack_c1;
    end
  end

  assign hold_full = req_t ^ ack_c2;

  // Request arrives in the link domain through two flops
  always_ff @(posedge ser_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      req_l1 <= 1'b0;
      req_l2 <= 1'b0;
    end else begin
      req_l1 <= req_t;
      req_l2 <= req_l1;
    end
  end

  // Serialiser: start bit, frame, line, data MSB first, stop bit
  always_ff @(posedge ser_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ser_st  <= isr_pkg::SER_IDLE;
      ser_sh  <= '0;
      ser_cnt <= 4'h0;
      ack_l   <= 1'b0;
    end else begin
      unique case (ser_st)
        isr_pkg::SER_IDLE: begin
          if (req_l2 != ack_l) begin
            ser_sh <= hold_word;
            ack_l  <= ~ack_l;
            ser_st <= isr_pkg::SER_START;
          end
        end
        isr_pkg::SER_START: begin
          ser_cnt <= 4'(isr_pkg::SER_W - 1);
          ser_st  <= isr_pkg::SER_DATA;
        end
        isr_pkg::SER_DATA: begin
          ser_sh <= {ser_sh[isr_pkg::SER_W-2:0], 1'b0};
          if (ser_cnt == 4'h0) begin
            ser_st <= isr_pkg::SER_STOP;
          end else begin
            ser_cnt <= ser_cnt - 4'h1;
          end
        end
        isr_pkg::SER_STOP: begin
          ser_st <= isr_pkg::SER_IDLE;
        end
      endcase
    end
  end

  // Line level registered in the link domain
  always_ff @(posedge ser_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ser_q <= isr_pkg::SER_STOP_BIT;
    end else begin
      unique case (ser_st)
        isr_pkg::SER_START: ser_q <= isr_pkg::SER_START_BIT;
        isr_pkg::SER_DATA:  ser_q <= ser_sh[isr_pkg::SER_W-1];
        isr_pkg::SER_IDLE,
        isr_pkg::SER_STOP:  ser_q <= isr_pkg::SER_STOP_BIT;
      endcase
    end
  end

  // Differential pair from the one registered level
  assign ser_p_o = ser_q;
  assign ser_n_o = ~ser_q;

endmodule : isr_readout_top

// [rtl/isr_pkg.sv]
// Shared constants for the image sensor readout and output block
package isr_pkg;
  // Word widths
  localparam int PIX_W        = 10;     // Converted sample width
  localparam int CFG_W        = 16;     // Configuration word width
  localparam int CNT_W        = 11;     // Row and column counter width
  localparam int N_COLOUR     = 4;      // Colour channels of the mosaic
  // Default image geometry, in pixel clocks and rows
  localparam int ACT_COLS     = 640;
  localparam int ACT_ROWS     = 480;
  localparam int HBLANK       = 244;
  localparam int VBLANK       = 29;
  localparam int DARK_ROWS    = 4;      // Shielded rows read ahead of the image
  localparam int BLACK_LOG2   = 8;      // Log2 of shielded samples averaged
  // Pixel rate divider: master clocks per pixel
  localparam int PIX_DIV      = 2;
  // Default exposure in row times
  localparam logic [15:0] EXPOSURE_DEF = 16'h01e0;
  // Digital gain is unsigned with this many fraction bits
  localparam int GAIN_FRAC    = 8;
  // Sample codes treated as defective when correction is on
  localparam logic [9:0] DEFECT_HI = 10'h3ff;
  localparam logic [9:0] DEFECT_LO = 10'h000;
  // Mode pin patterns, {hi, lo}
  localparam logic [1:0] MODE_PAR = 2'h0;
  localparam logic [1:0] MODE_SER = 2'h1;
  // Serial word: {frame, line, data}
  localparam int SER_W        = PIX_W + 2;
  // Serial framing bit levels
  localparam logic SER_START_BIT = 1'b1;
  localparam logic SER_STOP_BIT  = 1'b0;
  // Serialiser states, Gray along the path
  typedef enum logic [1:0] {
    SER_IDLE  = 2'b00,
    SER_START = 2'b01,
    SER_DATA  = 2'b11,
    SER_STOP  = 2'b10
  } isr_ser_e;
endpackage : isr_pkg

// [rtl/isr_pix_if.sv]
// Pixel stream between the timing generator and the correction stage
`timescale 1ns/1ps
interface isr_pix_if;
  logic                    valid;
  logic                    lv;
  logic                    fv;
  logic [1:0]              colour;
  logic [isr_pkg::PIX_W-1:0] data;
  modport src (output valid, output lv, output fv, output colour, output data);
  modport snk (input valid, input lv, input fv, input colour, input data);
endinterface : isr_pix_if

// [rtl/isr_pix_proc.sv]
// Digital offset, gain and defect correction on the pixel stream
`timescale 1ns/1ps
module isr_pix_proc (
  // Clock and reset
  input  wire logic                                   clk_i,
  input  wire logic                                   resetn_i,
  // Correction settings
  input  wire logic [isr_pkg::PIX_W-1:0]              black_i,
  input  wire logic [isr_pkg::N_COLOUR-1:0][15:0]     dig_offset_i,
  input  wire logic [isr_pkg::N_COLOUR-1:0][15:0]     dig_gain_i,
  input  wire logic                                   defect_en_i,
  // Streams
  isr_pix_if.snk                                      raw,
  isr_pix_if.src                                      cor
);
  logic [isr_pkg::PIX_W-1:0] last_val [isr_pkg::N_COLOUR];
  logic signed [12:0]        lvl;
  logic [28:0]               prod;
  logic [isr_pkg::PIX_W-1:0] sat;
  logic [isr_pkg::PIX_W-1:0] next_data;
  logic                      bad;

  // Black level, colour offset, colour gain, then saturation
  always_comb begin
    lvl = $signed({3'h0, raw.data}) - $signed({3'h0, black_i})
        + $signed(dig_offset_i[raw.colour][12:0]);
    if (lvl < 13'sh0) begin
      prod = 29'h0;
    end else begin
      prod = 29'(lvl[11:0]) * 29'(dig_gain_i[raw.colour]);
    end
    if (prod[28:isr_pkg::GAIN_FRAC] > 21'(isr_pkg::DEFECT_HI)) begin
      sat = isr_pkg::DEFECT_HI;
    end else begin
      sat = prod[isr_pkg::GAIN_FRAC +: isr_pkg::PIX_W];
    end
    bad = defect_en_i && raw.lv
        && (raw.data == isr_pkg::DEFECT_HI || raw.data == isr_pkg::DEFECT_LO);
    next_data = bad ? last_val[raw.colour] : sat;
    if (!raw.lv) begin
      next_data = '0;
    end
  end

  // Remember the last good value of each colour for substitution
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < isr_pkg::N_COLOUR; i++) begin
        last_val[i] <= '0;
      end
    end else if (raw.valid && raw.lv) begin
      last_val[raw.colour] <= next_data;
    end
  end

  // Output stage register
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cor.valid  <= 1'b0;
      cor.lv     <= 1'b0;
      cor.fv     <= 1'b0;
      cor.colour <= 2'h0;
      cor.data   <= '0;
    end else begin
      cor.valid <= raw.valid;
      if (raw.valid) begin
        cor.lv     <= raw.lv;
        cor.fv     <= raw.fv;
        cor.colour <= raw.colour;
        cor.data   <= next_data;
      end
    end
  end
endmodule : isr_pix_proc

// [dv/isr_monitor.sv]
// Pin-level checks for the readout block
`timescale 1ns/1ps
module isr_monitor #(
  parameter int ACT_COLS  = 640,
  parameter int ACT_ROWS  = 480,
  parameter int HBLANK    = 244,
  parameter int VBLANK    = 29,
  parameter int DARK_ROWS = 4
) (
  // Clocks and reset
  input wire logic        clk_i,
  input wire logic        ser_clk_i,
  input wire logic        resetn_i,
  // Mode and exposure
  input wire logic        function_select_hi_i,
  input wire logic        function_select_lo_i,
  input wire logic [15:0] exposure_rows_i,
  // Row control
  input wire logic        row_reset_o,
  input wire logic [10:0] row_reset_addr_o,
  input wire logic        row_read_o,
  input wire logic [10:0] row_read_addr_o,
  // Pixel outputs
  input wire logic [9:0]  pix_data_o,
  input wire logic        line_valid_o,
  input wire logic        frame_valid_o,
  input wire logic        sample_out_clock_o,
  input wire logic        ser_p_o,
  input wire logic        ser_n_o
);
  localparam int FRM     = DARK_ROWS + ACT_ROWS + VBLANK;
  localparam int ROW_CLK = 2 * (ACT_COLS + HBLANK);
  logic [2:0] rst_cnt;
  logic [3:0] ser_pos;
  int         lv_cnt;
  int         e_eff;
  int         tgt;
  logic       par;
  // Parallel pattern and the row an exposure aims at
  assign par = !function_select_hi_i && !function_select_lo_i;
  assign e_eff = (int'(exposure_rows_i) > FRM - 1) ? FRM - 1 : int'(exposure_rows_i);
  assign tgt = (int'(row_read_addr_o) + e_eff) % FRM;
  // Cycles since release, saturating
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) rst_cnt <= 3'h0;
    else if (rst_cnt != 3'h7) rst_cnt <= rst_cnt + 3'h1;
  end
  // Length of the current line pulse
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) lv_cnt <= 0;
    else lv_cnt <= line_valid_o ? lv_cnt + 1 : 0;
  end
  // Bit position within a serial frame
  always_ff @(posedge ser_clk_i or negedge resetn_i) begin
    if (!resetn_i) ser_pos <= 4'h0;
    else if (ser_pos != 4'h0) ser_pos <= (ser_pos == 4'hd) ? 4'h0 : ser_pos + 4'h1;
    else if (ser_p_o) ser_pos <= 4'h1;
  end
  property p_pclk;
    @(posedge clk_i) disable iff (!resetn_i)
    rst_cnt == 3'h7 |-> sample_out_clock_o != $past(sample_out_clock_o);
  endproperty
  a_pclk: assert property (p_pclk)
    else $error("pixel clock missed a toggle");
  property p_exp;
    @(posedge clk_i) disable iff (!resetn_i)
    (row_read_o || row_reset_o) |-> row_read_o == (row_read_addr_o < DARK_ROWS + ACT_ROWS)
      && row_reset_o == (tgt < DARK_ROWS + ACT_ROWS) && (!row_reset_o || row_reset_addr_o == tgt);
  endproperty
  a_exp: assert property (p_exp)
    else $error("row reset does not match exposure");
  property p_row;
    @(posedge clk_i) disable iff (!resetn_i)
    par && row_read_o && row_read_addr_o != DARK_ROWS + ACT_ROWS - 1 |-> ##ROW_CLK row_read_o
      && row_read_addr_o == ($past(row_read_addr_o, ROW_CLK) + 11'h1) % FRM;
  endproperty
  a_row: assert property (p_row)
    else $error("row read spacing or order wrong");
  property p_lv;
    @(posedge clk_i) disable iff (!resetn_i)
    $fell(line_valid_o) |-> lv_cnt == 2 * ACT_COLS;
  endproperty
  a_lv: assert property (p_lv)
    else $error("line pulse length wrong");
  property p_fv;
    @(posedge clk_i) disable iff (!resetn_i)
    line_valid_o |-> frame_valid_o;
  endproperty
  a_fv: assert property (p_fv)
    else $error("line outside frame");
  property p_hold;
    @(posedge clk_i) disable iff (!resetn_i)
    $changed({pix_data_o, line_valid_o, frame_valid_o}) |-> sample_out_clock_o;
  endproperty
  a_hold: assert property (p_hold)
    else $error("data moved near pixel clock rise");
  property p_quiet;
    @(posedge clk_i) disable iff (!resetn_i)
    rst_cnt == 3'h7 && !par |-> pix_data_o == 10'h0 && !line_valid_o && !frame_valid_o;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("parallel lines active outside parallel mode");
  sequence s_start;
    ser_pos == 4'h0 && ser_p_o;
  endsequence
  sequence s_stop;
    !ser_p_o && ser_n_o;
  endsequence
  property p_frame;
    @(posedge ser_clk_i) disable iff (!resetn_i)
    s_start |-> ##13 s_stop;
  endproperty
  a_frame: assert property (p_frame)
    else $error("serial frame has no stop bit");
  property p_compl;
    @(posedge ser_clk_i) disable iff (!resetn_i)
    ser_n_o == !ser_p_o && (!par || !ser_p_o);
  endproperty
  a_compl: assert property (p_compl)
    else $error("serial pair not complementary or not idle");
endmodule : isr_monitor

bind isr_readout_top isr_monitor #(
  .ACT_COLS(ACT_COLS), .ACT_ROWS(ACT_ROWS), .HBLANK(HBLANK), .VBLANK(VBLANK),
  .DARK_ROWS(DARK_ROWS)
) i_isr_monitor (
  .clk_i, .ser_clk_i, .resetn_i, .function_select_hi_i, .function_select_lo_i,
  .exposure_rows_i, .row_reset_o, .row_reset_addr_o, .row_read_o, .row_read_addr_o,
  .pix_data_o, .line_valid_o, .frame_valid_o, .sample_out_clock_o, .ser_p_o, .ser_n_o
);

// [dv/isr_host_model.sv]
// Host receiver for the parallel and serial pixel streams
`timescale 1ns/1ps
module isr_host_model #(
  parameter int COLS = 16
) (
  // Reset and link clock
  input wire logic       resetn_i,
  input wire logic       ser_clk_i,
  // Streams
  input wire logic       pclk_i,
  input wire logic       lv_i,
  input wire logic       fv_i,
  input wire logic [9:0] data_i,
  input wire logic       ser_p_i
);
  logic [9:0]  cap [2*COLS];
  logic        lv_q;
  logic        fv_q;
  logic [11:0] ser_sh;
  logic [11:0] ser_word;
  int          pix_cnt, pix_last, line_cnt, line_last, cap_idx, ser_pos, ser_cnt, ser_bad;
  // Parallel capture on the pixel clock rise
  always @(posedge pclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {pix_cnt, pix_last, line_cnt, line_last, cap_idx} = '0;
      {lv_q, fv_q} = 2'h0;
    end else begin
      if (lv_i) begin
        pix_cnt++;
        if (cap_idx < 2 * COLS) cap[cap_idx] = data_i;
        cap_idx++;
      end
      if (lv_q && !lv_i) begin
        pix_last = pix_cnt;
        pix_cnt = 0;
        line_cnt++;
      end
      if (fv_q && !fv_i) line_last = line_cnt;
      if (!fv_i) {line_cnt, cap_idx} = '0;
      {lv_q, fv_q} = {lv_i, fv_i};
    end
  end
  // Serial receive in mid-bit: start, twelve bits first-high, stop
  always @(negedge ser_clk_i or negedge resetn_i) begin
    if (!resetn_i) {ser_pos, ser_cnt, ser_bad} = '0;
    else if (ser_pos == 0) ser_pos = ser_p_i ? 1 : 0;
    else if (ser_pos < 13) begin
      ser_sh = {ser_sh[10:0], ser_p_i};
      ser_pos++;
    end else begin
      if (ser_p_i) ser_bad++;
      ser_word = ser_sh;
      ser_cnt++;
      ser_pos = 0;
    end
  end
endmodule : isr_host_model

// [dv/isr_readout_top_tb.sv]
// Self-checking bench for the readout block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin miscompares++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module isr_readout_top_tb;
  localparam int COLS = 16;
  localparam int ROWS = 8;
  localparam int DARK = 16;
  localparam int FRM  = DARK + ROWS + 2;
  localparam int ROWC = 2 * (COLS + 4);
  // Stimulus
  logic             clk_i     = 1'b0;
  logic             ser_clk_i = 1'b0;
  logic             resetn_i  = 1'b0;
  logic             sel_hi    = 1'b0;
  logic             sel_lo    = 1'b0;
  logic [15:0]      exposure  = 16'h0003;
  logic [9:0]       adc       = 10'h100;
  logic [3:0][15:0] dig_gain  = {16'h0300, 16'h0200, 16'h0180, 16'h0100};
  logic [3:0][15:0] dig_off   = {16'h01ff, 16'h0030, 16'h0020, 16'hff00};
  // Observed
  wire logic        row_rst, row_rd, lv, fv, pclk, ser_p, ser_n;
  wire logic [10:0] rst_addr, rd_addr;
  wire logic [9:0]  pix;
  int               miscompares = 0;
  int               n_tests = 0;
  int               reads = 0;
  int               resets = 0;
  int               pclks = 0;
  // Master clock and unrelated link clock
  always #2.5 clk_i = ~clk_i;
  initial begin
    #7.3;
    forever #40 ser_clk_i = ~ser_clk_i;
  end
  // Converter: shielded and blank rows low, image rows higher
  always @(negedge clk_i) adc <= (rd_addr >= DARK && rd_addr < DARK + ROWS) ? 10'h180 : 10'h100;
  // Event counters
  always @(posedge clk_i) reads <= reads + (row_rd === 1'b1);
  always @(posedge clk_i) resets <= resets + (row_rst === 1'b1);
  always @(posedge pclk) pclks <= pclks + 1;
  isr_readout_top #(
    .ACT_COLS(COLS), .ACT_ROWS(ROWS), .HBLANK(4), .VBLANK(2), .DARK_ROWS(DARK)
  ) i_isr_readout_top (
    .clk_i(clk_i), .ser_clk_i(ser_clk_i), .resetn_i(resetn_i),
    .function_select_hi_i(sel_hi), .function_select_lo_i(sel_lo),
    .exposure_rows_i(exposure), .ana_gain_i(dig_gain), .ana_offset_i(dig_off),
    .dig_gain_i(dig_gain), .dig_offset_i(dig_off), .defect_en_i(1'b0),
    .row_reset_o(row_rst), .row_reset_addr_o(rst_addr), .row_read_o(row_rd),
    .row_read_addr_o(rd_addr), .afe_colour_o(), .afe_gain_o(), .afe_offset_o(),
    .adc_sample_o(), .adc_data_i(adc), .pix_data_o(pix), .line_valid_o(lv),
    .frame_valid_o(fv), .sample_out_clock_o(pclk), .ser_p_o(ser_p), .ser_n_o(ser_n)
  );
  isr_host_model #(.COLS(COLS)) i_isr_host_model (
    .resetn_i(resetn_i), .ser_clk_i(ser_clk_i), .pclk_i(pclk), .lv_i(lv), .fv_i(fv),
    .data_i(pix), .ser_p_i(ser_p)
  );
  // Expected corrected code for a colour: image minus black, offset, gain, clip
  function automatic logic [9:0] expv(input int c);
    int v;
    v = 'h80 + int'($signed(dig_off[c][12:0]));
    if (v < 0) v = 0;
    v = (v * int'(dig_gain[c])) >> 8;
    return (v > 'h3ff) ? 10'h3ff : v[9:0];
  endfunction : expv
  // Reset with mode pins and exposure set only while held
  task automatic do_reset(input logic hi, input logic lo, input logic [15:0] e);
    @(negedge clk_i);
    resetn_i = 1'b0;
    sel_hi = hi;
    sel_lo = lo;
    exposure = e;
    repeat (40) @(negedge clk_i);
    resetn_i <= 1'b1;
  endtask : do_reset
  // Three parallel frames: geometry and per-colour values
  task automatic t_parallel();
    int c;
    do_reset(1'b0, 1'b0, 16'h0003);
    repeat (3 * FRM * ROWC) @(negedge clk_i);
    `CHK("lines per frame", ROWS, i_isr_host_model.line_last)
    `CHK("pixels per line", COLS, i_isr_host_model.pix_last)
    for (int k = 0; k < 2 * COLS; k++) begin
      c = 2 * ((k / COLS) % 2) + k % 2;
      `CHK("pixel", expv(c), i_isr_host_model.cap[k])
    end
  endtask : t_parallel
  // Clamped exposure: each row read once, in-range rows reset once per frame
  task automatic t_exposure();
    int r0;
    int s0;
    do_reset(1'b0, 1'b0, 16'hffff);
    r0 = reads;
    s0 = resets;
    repeat (FRM * ROWC) @(negedge clk_i);
    `CHK("rows read", DARK + ROWS, reads - r0)
    `CHK("rows reset", DARK + ROWS, resets - s0)
  endtask : t_exposure
  // Serial mode: framed words at the link's pace, parallel lines quiet
  task automatic t_serial();
    int n;
    do_reset(1'b0, 1'b1, 16'h0003);
    repeat (8000) @(negedge clk_i);
    n = i_isr_host_model.ser_cnt;
    `CHK("serial words", 1'b1, n >= 20 && n <= 36)
    `CHK("serial stop", 0, i_isr_host_model.ser_bad)
    `CHK("serial qualifiers", 2'h0, i_isr_host_model.ser_word[11:10])
    `CHK("parallel quiet", 0, i_isr_host_model.pix_cnt)
  endtask : t_serial
  // Unused patterns: no lines, pixel clock still running at half rate
  task automatic t_unused();
    int p0;
    for (int m = 2; m < 4; m++) begin
      do_reset(m[1], m[0], 16'h0003);
      p0 = pclks;
      repeat (2 * ROWC + 1) @(negedge clk_i);
      `CHK("pclk rises", ROWC, pclks - p0)
      `CHK("unused lines", 0, i_isr_host_model.pix_cnt)
    end
  endtask : t_unused
  // Verdict and end of run
  task automatic report_and_stop();
    if (miscompares == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  // Main sequence
  initial begin
    t_parallel();
    t_exposure();
    t_serial();
    t_unused();
    report_and_stop();
  end
  // Watchdog
  initial begin
    #150000;
    miscompares++;
    report_and_stop();
  end
endmodule : isr_readout_top_tb
